// *** i2c_ctrl_model.sv ***
`timescale 1ns/10ps
module i2c_ctrl_model (
   input  wire logic clk,
   input  wire logic sda_line,
   output      logic scl,
   output      logic sda_drv
);
   // Bus idles released; pull-up holds both lines high
   initial begin
      scl     = 1'b1;
      sda_drv = 1'b1;
   end
   // Quarter bit is two clocks, so one bit lasts 320 ns
   task automatic q(input int n);
      repeat (n) @(negedge clk);
   endtask : q
   // Data moves while clock low; sampled late in high phase for margin
   task automatic bit_io(input logic b, output logic r);
      scl = 1'b0;
      q(2);
      sda_drv = b;
      q(2);
      scl = 1'b1;
      q(3);
      r = sda_line;
      q(1);
   endtask : bit_io
   task automatic start;
      q(2);
      sda_drv = 1'b0;
      q(2);
   endtask : start
   task automatic stop;
      scl = 1'b0;
      q(2);
      sda_drv = 1'b0;
      q(2);
      scl = 1'b1;
      q(2);
      sda_drv = 1'b1;
      q(2);
   endtask : stop
   // MSB first, then release for the acknowledge slot
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, ack);
   endtask : wr_byte
   // Low acknowledge asks for another status byte
   task automatic rd_byte(input logic m_ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(m_ack, r);
   endtask : rd_byte
endmodule : i2c_ctrl_model

// *** i2c_tuner_synth_control.sv ***
`timescale 1ns/10ps
// Summary of operation
// - Address byte last bit: 0 writes to device, 1 reads status.
// - Device acknowledges its address and every written data byte.
// - Unacknowledged status byte acts as stop; read data stops.
// - First bit of first data byte: 0 ratio high, 1 control.
// - Ratio high byte pairs with ratio low; control pairs with port.
// - Further byte pairs keep decoding until a bus stop.
// - Partial byte is discarded; last full value is kept.
// - Fifteen-bit ratio register sets the programmable divider.
// - Fixed divide-by-eight prescaler feeds the programmable divider.
// - Ratio select bit: 1 gives 512, 0 gives 1024 reference division.
// - Pump current select: 1 high current, 0 low current.
// - Low pump current forced while locked.
// - Pump disable bit turns the charge pump off.
// - Drive off bit switches the drive amplifier output off.
// - Test enable activates test modes; otherwise only ratio select matters.
// - Test modes force pump, lock flag and divider pulses onto ports.
// - Port bit 0 releases the open-collector port, 1 pulls it on.
// - Power-loss flag set at power-up, cleared by stop ending a read.
// - During power loss programmed data is lost and ports released.
// - Lock indicator reads 1 when locked, 0 when not.
// - Status bits show levels of port lines seven, five and four.
// - Lowest three status bits carry the converter code.
// - Converter code runs 000 to 100 with rising input level.
// - Address is fixed 11000, two strap bits, then direction.
// - Ratio bytes go MSB first: bits 14..8, then bits 7..0.
module i2c_tuner_synth_control
   import synth_ctl_pkg::*;
(
   input  wire logic       CLK,
   input  wire logic       RST_N,
   input  wire logic       SCL,
   input  wire logic       SDA_IN,
   output      logic       SDA_OUT,
   output      logic       SDA_OE_N,
   input  wire logic [1:0] VARIABLE_ADDRESS_BITS,
   input  wire logic       POWER_LOSS,
   input  wire logic       RF_IN,
   input  wire logic [3:0] PORT_LINE_IN,
   output      logic [3:0] PORT_LINE_OUT,
   output      logic [3:0] PORT_LINE_OE_N,
   input  wire logic [3:0] LEVEL_COMPARE,
   output      logic       PUMP_SOURCE,
   output      logic       PUMP_SINK,
   output      logic       PUMP_HIGH_CURRENT,
   output      logic       DRIVE_ENABLE
);
   typedef struct packed {
      // Synchronisers: index 0 first stage, index 1 second stage
      logic [1:0]  scl_s;
      logic [1:0]  sda_s;
      logic        scl_d;
      logic        sda_d;
      logic [1:0]  pl_s;
      logic [1:0]  rf_s;
      logic [3:0]  port_s1;
      logic [3:0]  port_s2;
      logic [3:0]  cmp_s1;
      logic [3:0]  cmp_s2;
      logic [1:0]  adr_s1;
      logic [1:0]  adr_s2;
      // Bus engine
      i2c_state_t  st;
      logic [2:0]  bit_cnt;
      logic        byte_full;
      logic [7:0]  shift;
      byte_kind_t  kind;
      logic        sda_low;
      logic        in_read;
      // Programmed data
      logic [14:0] ratio;
      logic [7:0]  ctrl;
      logic [3:0]  port_ctl;
      logic        ratio_512;
      logic        por;
      // Registered outputs
      logic        fpd_half;
      logic [3:0]  port_on;
      logic        pump_src;
      logic        pump_snk;
      logic        pump_hi;
      logic        drive_en;
   } ctl_state_t;

   ctl_state_t  cur, n;
   logic [1:0]  rst_sync_ff;
   logic        rst_n;
   logic        scl, sda, scl_rise, scl_fall, start_cond, stop_cond, power_lost;
   logic        test_en, force_src, force_snk, p7_half, p7_fpd;
   logic [2:0]  test_sel;
   logic [2:0]  converter_code;
   logic        lock_flag;
   logic [7:0]  status_byte;
   logic [7:0]  byte_in;
   logic        addr_match;

   synth_if sif ();

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   synth_dividers #(.W(RATIO_W)) u_div (
      .clk   (CLK),
      .rst_n (rst_n),
      .sif   (sif.dividers)
   );

   phase_lock_monitor #(.WIN(LOCK_WIN_CYC), .STREAK(LOCK_STREAK)) u_lock (
      .clk   (CLK),
      .rst_n (rst_n),
      .sif   (sif.monitor)
   );

   assign sif.rf_level  = cur.rf_s[1];
   assign sif.ratio     = cur.ratio;
   assign sif.ratio_512 = cur.ratio_512;

   // Bus conditions from the second sync stage and its delayed copy
   assign scl        = cur.scl_s[1];
   assign sda        = cur.sda_s[1];
   assign scl_rise   = scl & ~cur.scl_d;
   assign scl_fall   = ~scl & cur.scl_d;
   assign start_cond = scl & cur.scl_d & cur.sda_d & ~sda;
   assign stop_cond  = scl & cur.scl_d & ~cur.sda_d & sda;
   assign power_lost = cur.pl_s[1];
   assign byte_in    = {cur.shift[6:0], sda};
   assign addr_match = (byte_in[7:3] == ADDR_FIXED) &&
                       (byte_in[2:1] == cur.adr_s2);

   // Test mode decode; ratio select stays latched while testing
   assign test_en   = cur.ctrl[CTL_TEST_EN];
   assign test_sel  = {cur.ctrl[CTL_TS_HIGH], cur.ctrl[CTL_TS_MID], cur.ctrl[CTL_RATIO_SEL]};
   assign force_src = test_en && (test_sel[2:1] == 2'b00);
   assign force_snk = test_en && (test_sel[2:1] == 2'b01);
   assign p7_half   = test_en && (test_sel == 3'b101);
   assign p7_fpd    = test_en && (test_sel[2:1] == 2'b11);

   // Thermometer comparators give a code rising with input level
   assign converter_code = 3'($countones(cur.cmp_s2));
   assign lock_flag      = force_snk | (~force_src & sif.locked);
   assign status_byte    = {cur.por, lock_flag, cur.port_s2[PIDX_SEVEN],
                            cur.port_s2[PIDX_FIVE], cur.port_s2[PIDX_FOUR],
                            converter_code};

   // Next-state logic for the whole block
   always_comb begin
      n          = cur;
      n.scl_s    = {cur.scl_s[0], SCL};
      n.sda_s    = {cur.sda_s[0], SDA_IN};
      n.scl_d    = cur.scl_s[1];
      n.sda_d    = cur.sda_s[1];
      n.pl_s     = {cur.pl_s[0], POWER_LOSS};
      n.rf_s     = {cur.rf_s[0], RF_IN};
      n.port_s1  = PORT_LINE_IN;
      n.port_s2  = cur.port_s1;
      n.cmp_s1   = LEVEL_COMPARE;
      n.cmp_s2   = cur.cmp_s1;
      n.adr_s1   = VARIABLE_ADDRESS_BITS;
      n.adr_s2   = cur.adr_s1;
      if (scl_rise) begin
         n.shift   = byte_in;
         n.bit_cnt = cur.bit_cnt + 3'h1;
      end
      unique case (cur.st)
         ST_IDLE: begin
         end
         ST_ADDR: begin
            if (scl_rise && cur.bit_cnt == 3'h7) begin
               n.byte_full = 1'b1;
               n.in_read   = byte_in[ADDR_DIR_BIT] & addr_match;
               if (!addr_match) begin
                  n.st = ST_IDLE;
               end
            end
            if (scl_fall && cur.byte_full) begin
               n.byte_full = 1'b0;
               n.st        = ST_ADDR_ACK;
               n.sda_low   = 1'b1;
            end
         end
         ST_ADDR_ACK: begin
            if (scl_fall) begin
               n.bit_cnt = 3'h0;
               if (cur.in_read) begin
                  n.st      = ST_READ;
                  n.shift   = status_byte;
                  n.sda_low = ~status_byte[7];
               end else begin
                  n.st      = ST_WRITE;
                  n.sda_low = 1'b0;
               end
            end
         end
         ST_WRITE: begin
            // Commit only whole bytes; a cut byte never lands
            if (scl_rise && cur.bit_cnt == 3'h7) begin
               n.byte_full = 1'b1;
               unique case (cur.kind)
                  KIND_FIRST: begin
                     if (byte_in[BYTE_TYPE_BIT]) begin
                        n.ctrl = byte_in;
                        if (!byte_in[CTL_TEST_EN]) begin
                           n.ratio_512 = byte_in[CTL_RATIO_SEL];
                        end
                        n.kind = KIND_PORT;
                     end else begin
                        n.ratio[14:8] = byte_in[6:0];
                        n.kind        = KIND_RATIO_LO;
                     end
                  end
                  KIND_RATIO_LO: begin
                     n.ratio[7:0] = byte_in;
                     n.kind       = KIND_FIRST;
                  end
                  KIND_PORT: begin
                     n.port_ctl = byte_in[7:PORT_FIELD_LSB];
                     n.kind     = KIND_FIRST;
                  end
               endcase
            end
            if (scl_fall && cur.byte_full) begin
               n.byte_full = 1'b0;
               n.st        = ST_WRITE_ACK;
               n.sda_low   = 1'b1;
            end
         end
         ST_WRITE_ACK: begin
            if (scl_fall) begin
               n.st      = ST_WRITE;
               n.sda_low = 1'b0;
               n.bit_cnt = 3'h0;
            end
         end
         ST_READ: begin
            if (scl_rise && cur.bit_cnt == 3'h7) begin
               n.byte_full = 1'b1;
            end
            if (scl_fall) begin
               if (cur.byte_full) begin
                  n.byte_full = 1'b0;
                  n.st        = ST_READ_ACK;
                  n.sda_low   = 1'b0;
               end else begin
                  // Rising edge already shifted; next bit now sits on top
                  n.sda_low = ~cur.shift[7];
               end
            end
         end
         ST_READ_ACK: begin
            if (scl_rise) begin
               if (sda) begin
                  n.st = ST_IDLE;
               end else begin
                  n.byte_full = 1'b1;
               end
            end
            if (scl_fall && cur.byte_full) begin
               n.byte_full = 1'b0;
               n.st        = ST_READ;
               n.bit_cnt   = 3'h0;
               n.shift     = status_byte;
               n.sda_low   = ~status_byte[7];
            end
         end
      endcase
      // Bus start and stop override any byte in flight
      if (start_cond) begin
         n.st        = ST_ADDR;
         n.bit_cnt   = 3'h0;
         n.byte_full = 1'b0;
         n.sda_low   = 1'b0;
         n.kind      = KIND_FIRST;
      end else if (stop_cond) begin
         n.st        = ST_IDLE;
         n.byte_full = 1'b0;
         n.sda_low   = 1'b0;
         if (cur.in_read) begin
            n.por     = 1'b0;
            n.in_read = 1'b0;
         end
      end
      // Supply loss wins over any clear and wipes programming
      if (power_lost) begin
         n.por       = 1'b1;
         n.ratio     = RATIO_RESET;
         n.ctrl      = CTRL_RESET;
         n.port_ctl  = PORT_RESET;
         n.ratio_512 = 1'b0;
      end
      // Output drive, registered
      if (sif.fpd) begin
         n.fpd_half = ~cur.fpd_half;
      end
      n.port_on = cur.port_ctl;
      if (p7_half) begin
         n.port_on[PIDX_SEVEN] = cur.fpd_half;
      end
      if (p7_fpd) begin
         n.port_on[PIDX_SEVEN] = sif.fpd;
         n.port_on[PIDX_SIX]   = sif.fcomp;
      end
      if (power_lost) begin
         n.port_on = 4'h0;
      end
      n.pump_src = ~cur.ctrl[CTL_PUMP_DIS] & (force_src |
                   (~force_snk & ~force_src & sif.pfd_dn));
      n.pump_snk = ~cur.ctrl[CTL_PUMP_DIS] & (force_snk |
                   (~force_snk & ~force_src & sif.pfd_up));
      n.pump_hi  = cur.ctrl[CTL_PUMP_HI] & ~sif.locked;
      n.drive_en = ~cur.ctrl[CTL_DRIVE_OFF];
   end

   // Power-up leaves the loss flag set and all ports released
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         cur           <= '0;
         cur.st        <= ST_IDLE;
         cur.kind      <= KIND_FIRST;
         cur.scl_s     <= 2'h3;
         cur.sda_s     <= 2'h3;
         cur.scl_d     <= 1'b1;
         cur.sda_d     <= 1'b1;
         cur.ratio     <= RATIO_RESET;
         cur.ctrl      <= CTRL_RESET;
         cur.port_ctl  <= PORT_RESET;
         cur.por       <= 1'b1;
         cur.drive_en  <= 1'b1;
      end else begin
         cur <= n;
      end
   end

   // Open-drain pins: only the enable moves
   assign SDA_OUT           = 1'b0;
   assign SDA_OE_N          = ~cur.sda_low;
   assign PORT_LINE_OUT     = 4'h0;
   assign PORT_LINE_OE_N    = ~cur.port_on;
   assign PUMP_SOURCE       = cur.pump_src;
   assign PUMP_SINK         = cur.pump_snk;
   assign PUMP_HIGH_CURRENT = cur.pump_hi;
   assign DRIVE_ENABLE      = cur.drive_en;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!rst_n);

   AST_ACK_DRIVE: assert property (
      (cur.st == ST_ADDR_ACK || cur.st == ST_WRITE_ACK) |-> !SDA_OE_N)
      else $error("acknowledge slot not driven low");
   AST_NACK_ENDS_READ: assert property (
      (cur.st == ST_READ_ACK && scl_rise && sda && !start_cond) |=>
      (cur.st == ST_IDLE && SDA_OE_N) [*2])
      else $error("read continued after missing acknowledge");
   AST_BYTE_PAIR: assert property (
      (cur.st == ST_WRITE && scl_rise && cur.bit_cnt == 3'h7 && cur.kind == KIND_FIRST
       && !start_cond && !stop_cond) |=>
      (cur.kind == (cur.shift[BYTE_TYPE_BIT] ? KIND_PORT : KIND_RATIO_LO)))
      else $error("byte pairing broken");
   AST_POR_CLEAR: assert property (
      (stop_cond && !start_cond && cur.in_read && !power_lost) |=> !cur.por)
      else $error("loss flag not cleared after read");
   AST_POWER_LOSS: assert property (
      power_lost |=> (cur.por && cur.ratio == RATIO_RESET) ##1 (PORT_LINE_OE_N == 4'hF))
      else $error("programming survived power loss");
   AST_LOCK_CURRENT: assert property (
      sif.locked |=> !PUMP_HIGH_CURRENT)
      else $error("high pump current while locked");
   AST_PUMP_OFF: assert property (
      cur.ctrl[CTL_PUMP_DIS] |=> (!PUMP_SOURCE && !PUMP_SINK))
      else $error("pump active while disabled");
   AST_DRIVE_OFF: assert property (
      $past(cur.ctrl[CTL_DRIVE_OFF]) |-> !DRIVE_ENABLE)
      else $error("drive amplifier on while switched off");
   AST_TEST_LOCK: assert property (
      (force_snk |-> status_byte[STS_LOCK]) and (force_src |-> !status_byte[STS_LOCK]))
      else $error("lock flag not forced by test mode");
endmodule : i2c_tuner_synth_control

// *** i2c_tuner_synth_control_tb_top.sv ***
`timescale 1ns/10ps
module i2c_tuner_synth_control_tb_top;
   import synth_ctl_pkg::*;
   logic       clk, rst_n, power_loss, rf_in, scl, sda_drv, sda_out, sda_oe_n;
   logic       drive_en, pump_hi, src, snk, ack;
   logic [1:0] straps;
   logic [3:0] pin, loe_n, lout, lvl;
   logic [7:0] st, c, p;
   int         err_count, checks;
   wire        sda_line = sda_drv & (sda_oe_n | sda_out);
   i2c_tuner_synth_control u_i2c_tuner_synth_control (.CLK(clk), .RST_N(rst_n), .SCL(scl),
      .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .VARIABLE_ADDRESS_BITS(straps),
      .POWER_LOSS(power_loss), .RF_IN(rf_in), .PORT_LINE_IN(pin), .PORT_LINE_OUT(lout),
      .PORT_LINE_OE_N(loe_n), .LEVEL_COMPARE(lvl), .PUMP_SOURCE(src), .PUMP_SINK(snk),
      .PUMP_HIGH_CURRENT(pump_hi), .DRIVE_ENABLE(drive_en));
   i2c_ctrl_model u_i2c_ctrl_model (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report;
      $display("errors %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   // Address byte: fixed bits, straps, direction
   function automatic logic [7:0] addr(input logic dir);
      return {ADDR_FIXED, straps, dir};
   endfunction : addr
   // Lock bit masked out; converter code is the count of comparators set
   function automatic logic [7:0] exp_st(input logic por);
      return {por, 1'b0, pin[3], pin[1], pin[0], 3'($countones(lvl))};
   endfunction : exp_st
   task automatic wr(input logic [7:0] d, input logic exp_ack);
      u_i2c_ctrl_model.wr_byte(d, ack);
      check({7'h0, ack}, {7'h0, exp_ack});
   endtask : wr
   // Two status bytes, second one refused, then one more byte that must read idle
   task automatic rd_status(input logic por);
      u_i2c_ctrl_model.start();
      wr(addr(1'b1), 1'b0);
      u_i2c_ctrl_model.rd_byte(1'b0, st);
      check(st & 8'hBF, exp_st(por));
      u_i2c_ctrl_model.rd_byte(1'b1, st);
      check(st & 8'hBF, exp_st(por));
      check({7'h0, sda_oe_n}, 8'h01);
      // Status never reads all ones, so a device still sending shows up here
      u_i2c_ctrl_model.rd_byte(1'b1, st);
      check(st, 8'hFF);
      u_i2c_ctrl_model.stop();
   endtask : rd_status
   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Hang guard well above the longest sequence
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      final_report();
   end
   // Main sequence
   initial begin
      rst_n      = 1'b0;
      power_loss = 1'b0;
      rf_in      = 1'b0;
      straps     = 2'h2;
      pin        = 4'h5;
      lvl        = 4'h0;
      void'($urandom(28));
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      repeat (8) @(negedge clk);
      rd_status(1'b1);
      for (int k = 0; k < 6; k++) begin
         pin    = 4'($urandom);
         lvl    = (k == 0) ? 4'hF : 4'($urandom);
         straps = 2'($urandom);
         c      = {1'b1, 1'($urandom), 1'b0, 1'($urandom), 2'h0, 2'($urandom)};
         p      = 8'($urandom);
         repeat (8) @(negedge clk);
         rd_status(1'b0);
         // Control/port pair then ratio pair in one transfer
         u_i2c_ctrl_model.start();
         wr(addr(1'b0), 1'b0);
         wr(c, 1'b0);
         wr(p, 1'b0);
         wr(8'h7F & 8'($urandom), 1'b0);
         wr(8'($urandom), 1'b0);
         u_i2c_ctrl_model.stop();
         check({4'h0, loe_n}, {4'h0, ~p[7:4]});
         check({4'h0, lout}, 8'h00);
         check({7'h0, drive_en}, {7'h0, ~c[CTL_DRIVE_OFF]});
         check({7'h0, pump_hi}, {7'h0, c[CTL_PUMP_HI]});
         check({6'h0, src, snk} & {8{c[CTL_PUMP_DIS]}}, 8'h00);
         // New control byte, port byte cut short
         u_i2c_ctrl_model.start();
         wr(addr(1'b0), 1'b0);
         wr(c ^ 8'h01, 1'b0);
         repeat (3) u_i2c_ctrl_model.bit_io(~p[7], ack);
         u_i2c_ctrl_model.stop();
         check({4'h0, loe_n}, {4'h0, ~p[7:4]});
         check({7'h0, drive_en}, {7'h0, c[CTL_DRIVE_OFF]});
         // Foreign address is not acknowledged
         u_i2c_ctrl_model.start();
         wr({ADDR_FIXED, ~straps, 1'b0}, 1'b1);
         u_i2c_ctrl_model.stop();
      end
      // Test modes force pump direction and the lock flag
      for (int m = 0; m < 2; m++) begin
         u_i2c_ctrl_model.start();
         wr(addr(1'b0), 1'b0);
         wr({3'b101, 2'b00, 1'(m), 2'h0}, 1'b0);
         u_i2c_ctrl_model.stop();
         check({6'h0, src, snk}, {6'h0, ~1'(m), 1'(m)});
         u_i2c_ctrl_model.start();
         wr(addr(1'b1), 1'b0);
         u_i2c_ctrl_model.rd_byte(1'b1, st);
         u_i2c_ctrl_model.stop();
         check({7'h0, st[STS_LOCK]}, {7'h0, 1'(m)});
      end
      power_loss = 1'b1;
      repeat (10) @(negedge clk);
      check({4'h0, loe_n}, 8'h0F);
      power_loss = 1'b0;
      repeat (10) @(negedge clk);
      rd_status(1'b1);
      rd_status(1'b0);
      final_report();
   end
endmodule : i2c_tuner_synth_control_tb_top

// *** phase_lock_monitor.sv ***
`timescale 1ns/10ps
module phase_lock_monitor
   import synth_ctl_pkg::*;
#(
   parameter int WIN    = LOCK_WIN_CYC,
   parameter int STREAK = LOCK_STREAK
) (
   input wire logic clk,
   input wire logic rst_n,
   synth_if.monitor sif
);
   typedef struct packed {
      logic       up;
      logic       dn;
      logic [7:0] err_cnt;
      logic [3:0] streak;
   } pfd_state_t;

   pfd_state_t cur, n;

   if (WIN < 1 || WIN > 255 || STREAK < 1 || STREAK > 15) begin : g_chk
      $error("phase_lock_monitor: window or streak out of range");
   end

   // Phase detector; both flags set means the edges met, so both clear
   always_comb begin
      n    = cur;
      n.up = cur.up | sif.fcomp;
      n.dn = cur.dn | sif.fpd;
      if (cur.up || cur.dn) begin
         n.err_cnt = (cur.err_cnt == 8'hFF) ? cur.err_cnt : cur.err_cnt + 8'h01;
      end
      if (n.up && n.dn) begin
         n.up      = 1'b0;
         n.dn      = 1'b0;
         n.err_cnt = 8'h00;
         // Short phase error counts toward lock, long one breaks it
         if (cur.err_cnt <= 8'(WIN)) begin
            n.streak = (cur.streak == 4'(STREAK)) ? cur.streak : cur.streak + 4'h1;
         end else begin
            n.streak = 4'h0;
         end
      end else if (cur.err_cnt > 8'(WIN)) begin
         n.streak = 4'h0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= n;
      end
   end

   assign sif.locked = (cur.streak == 4'(STREAK));
   assign sif.pfd_up = cur.up & ~cur.dn;
   assign sif.pfd_dn = cur.dn & ~cur.up;
endmodule : phase_lock_monitor

// *** synth_ctl_pkg.sv ***
package synth_ctl_pkg;
   // Bus address: fixed upper bits, then two strap bits, then direction
   localparam logic [4:0] ADDR_FIXED     = 5'h18;
   localparam int         ADDR_DIR_BIT   = 0;
   localparam int         BYTE_TYPE_BIT  = 7;
   // Control byte field positions (first bit sent is bit 7)
   localparam int         CTL_PUMP_HI    = 6;
   localparam int         CTL_TEST_EN    = 5;
   localparam int         CTL_PUMP_DIS   = 4;
   localparam int         CTL_TS_HIGH    = 3;
   localparam int         CTL_TS_MID     = 2;
   localparam int         CTL_RATIO_SEL  = 1;
   localparam int         CTL_DRIVE_OFF  = 0;
   // Port byte: controls sit in the upper nibble
   localparam int         PORT_FIELD_LSB = 4;
   localparam int         PIDX_SEVEN     = 3;
   localparam int         PIDX_SIX       = 2;
   localparam int         PIDX_FIVE      = 1;
   localparam int         PIDX_FOUR      = 0;
   // Status byte layout
   localparam int         STS_POR        = 7;
   localparam int         STS_LOCK       = 6;
   // Divider chain
   localparam int         RATIO_W        = 15;
   localparam int         PRESCALE       = 8;
   localparam int         REF_DIV_SHORT  = 512;
   localparam int         REF_DIV_LONG   = 1024;
   // Reset values
   localparam logic [14:0] RATIO_RESET   = 15'h0000;
   localparam logic [7:0]  CTRL_RESET    = 8'h00;
   localparam logic [3:0]  PORT_RESET    = 4'h0;
   // Lock detector: phase error window and streak length
   localparam int         CLK_PERIOD_NS  = 40;
   localparam int         LOCK_WINDOW_NS = 1000;
   localparam int         LOCK_WIN_CYC   = (LOCK_WINDOW_NS / CLK_PERIOD_NS < 1) ? 1 :
                                           LOCK_WINDOW_NS / CLK_PERIOD_NS;
   localparam int         LOCK_STREAK    = 4;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WRITE_ACK, ST_READ, ST_READ_ACK
   } i2c_state_t;

   typedef enum logic [1:0] {KIND_FIRST, KIND_RATIO_LO, KIND_PORT} byte_kind_t;
endpackage : synth_ctl_pkg

// *** synth_dividers.sv ***
`timescale 1ns/10ps
module synth_dividers
   import synth_ctl_pkg::*;
#(
   parameter int W = RATIO_W
) (
   input wire logic clk,
   input wire logic rst_n,
   synth_if.dividers sif
);
   typedef struct packed {
      logic         rf_d;
      logic [2:0]   pre_cnt;
      logic [W-1:0] prog_cnt;
      logic [9:0]   ref_cnt;
      logic         fpd;
      logic         fcomp;
   } div_state_t;

   div_state_t cur, n;
   logic       rf_edge;
   logic       pre_tick;
   logic [9:0] ref_last;

   if (W != RATIO_W) begin : g_chk
      $error("synth_dividers: ratio width must be fifteen");
   end

   assign rf_edge  = sif.rf_level & ~cur.rf_d;
   assign pre_tick = rf_edge && (cur.pre_cnt == 3'(PRESCALE - 1));
   assign ref_last = sif.ratio_512 ? 10'(REF_DIV_SHORT - 1) : 10'(REF_DIV_LONG - 1);

   // Prescaler feeds programmable divider; reference counts the clock
   always_comb begin
      n       = cur;
      n.rf_d  = sif.rf_level;
      n.fpd   = 1'b0;
      n.fcomp = 1'b0;
      if (rf_edge) begin
         n.pre_cnt = cur.pre_cnt + 3'h1;
      end
      if (pre_tick) begin
         // Ratio of zero behaves as one: every count plus one is at least zero, so each tick wraps
         if (W'(cur.prog_cnt + 1'b1) >= sif.ratio) begin
            n.prog_cnt = '0;
            n.fpd      = 1'b1;
         end else begin
            n.prog_cnt = cur.prog_cnt + 1'b1;
         end
      end
      if (cur.ref_cnt >= ref_last) begin
         n.ref_cnt = 10'h000;
         n.fcomp   = 1'b1;
      end else begin
         n.ref_cnt = cur.ref_cnt + 10'h001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
      end else begin
         cur <= n;
      end
   end

   assign sif.fpd   = cur.fpd;
   assign sif.fcomp = cur.fcomp;

   AST_REF_PERIOD: assert property (@(posedge clk) disable iff (!rst_n)
      (cur.fcomp && sif.ratio_512 && $stable(sif.ratio_512)) |-> (cur.ref_cnt == 10'h000))
      else $error("comparison pulse out of step with reference count");
endmodule : synth_dividers

// *** synth_if.sv ***
`timescale 1ns/10ps
interface synth_if;
   logic        rf_level;
   logic [14:0] ratio;
   logic        ratio_512;
   logic        fpd;
   logic        fcomp;
   logic        locked;
   logic        pfd_up;
   logic        pfd_dn;
   modport dividers (input rf_level, ratio, ratio_512, output fpd, fcomp);
   modport monitor  (input fpd, fcomp, output locked, pfd_up, pfd_dn);
   modport ctrl     (output rf_level, ratio, ratio_512, input fpd, fcomp, locked, pfd_up, pfd_dn);
endinterface : synth_if
